// >>> bench/tb_top.sv
/*
 * Testbench joining the initiator end and the bridge end on one bus.
 * Assumes the package and the interface are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic mclk_in = 1'b0;
   logic srst_in = 1'b1;
   logic req_valid_in = 1'b0;
   logic [3:0] req_cmd_in = 4'h0;
   logic [63:0] req_addr_in = 64'h0;
   logic req_wide_in = 1'b0;
   logic [63:0] req_data_in = 64'h0;
   logic [7:0] req_be_in = 8'h0;
   logic wd_ready_in = 1'b0;
   logic rd_valid_in = 1'b0;
   logic [63:0] rd_data_in = 64'h0;
   logic req_ready_out, done_out, abort_out, acked64_out, up_valid_out;
   logic wd_valid_out, rd_taken_out;
   logic [63:0] rd_data_out, up_addr_out, wd_data_out, got_addr;
   logic [7:0] wd_be_out;
   wide_bus_pkg::hub_kind_t up_kind_out, got_kind;
   logic hold = 1'b0;
   logic [71:0] wq[$];
   int n_fail = 0;
   int comparisons = 0;
   int n_claim = 0;

   wide_bus_if bus();
   wide_init_end wide_init_end_i (.mclk_in, .srst_in, .bus, .req_valid_in, .req_cmd_in,
      .req_addr_in, .req_wide_in, .req_data_in, .req_be_in, .req_ready_out, .done_out,
      .abort_out, .acked64_out, .rd_data_out);
   wide_bridge_end wide_bridge_end_i (.mclk_in, .srst_in, .bus, .up_valid_out, .up_kind_out,
      .up_addr_out, .wd_valid_out, .wd_data_out, .wd_be_out, .wd_ready_in, .rd_valid_in,
      .rd_data_in, .rd_taken_out);
   wide_bus_checker wide_bus_checker_i (.mclk_in, .srst_in, .frame_n(bus.frame_n),
      .irdy_n(bus.irdy_n), .req64_n(bus.req64_n), .cbe_n(bus.cbe_n), .devsel_n(bus.devsel_n),
      .trdy_n(bus.trdy_n), .ack64_n(bus.ack64_n), .ad(bus.ad), .ad_i_oe(bus.ad_i_oe),
      .ad_t_oe(bus.ad_t_oe), .par(bus.par), .par64(bus.par64), .par_i_oe(bus.par_i_oe),
      .par_t_oe(bus.par_t_oe), .par64_i_oe(bus.par64_i_oe), .par64_t_oe(bus.par64_t_oe));

   initial begin
      forever #2 mclk_in = ~mclk_in;
   end

   task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   function automatic wide_bus_pkg::hub_kind_t exp_kind(input logic [3:0] c);
      case (c)
         4'h1: return wide_bus_pkg::HUB_SPECIAL;
         4'h2: return wide_bus_pkg::HUB_IO_RD;
         4'h3: return wide_bus_pkg::HUB_IO_WR;
         4'h6, 4'hc, 4'he: return wide_bus_pkg::HUB_MEM_RD;
         4'h7, 4'hf: return wide_bus_pkg::HUB_MEM_WR;
         4'ha: return wide_bus_pkg::HUB_CFG_RD;
         4'hb: return wide_bus_pkg::HUB_CFG_WR;
         default: return wide_bus_pkg::HUB_NONE;
      endcase
   endfunction

   // Watches the hub side and drains buffered writes with random stalls.
   always @(posedge mclk_in) begin
      if (up_valid_out) begin
         n_claim++;
         got_kind = up_kind_out;
         got_addr = up_addr_out;
      end
      if (wd_valid_out && wd_ready_in) begin
         check("wd_word", {wd_be_out, wd_data_out}, wq.size() ? wq.pop_front() : 72'h0);
      end
      wd_ready_in <= !hold && ($urandom % 3 != 0);
   end

   task automatic xfer(input logic [3:0] c, input logic [63:0] a, input logic w);
      logic [63:0] d;
      logic [7:0] be;
      logic rsv;
      int n0;
      int t;
      d = {$urandom, $urandom};
      be = 8'($urandom);
      rsv = c inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9};
      n0 = n_claim;
      if (!rsv && c[0]) begin
         wq.push_back(w ? {be, d} : {4'h0, be[3:0], 32'h0, d[31:0]});
      end
      rd_data_in <= d;
      req_cmd_in <= c;
      req_addr_in <= a;
      req_wide_in <= w;
      req_data_in <= d;
      req_be_in <= be;
      req_valid_in <= 1'b1;
      for (t = 0; t < 60; t++) begin
         @(posedge mclk_in);
         if (req_ready_out === 1'b1) break;
      end
      req_valid_in <= 1'b0;
      for (t = 0; t < 90 && done_out !== 1'b1; t++) @(posedge mclk_in);
      check("done", done_out, 1'b1);
      check("abort", abort_out, rsv);
      check("claims", 72'(n_claim - n0), 72'(!rsv));
      check("rd_taken", rd_taken_out, !rsv && !c[0]);
      if (!rsv) begin
         check("kind", got_kind, exp_kind(c));
         check("addr", got_addr, a);
         check("acked64", acked64_out, w);
         if (!c[0]) begin
            check("rdata", w ? rd_data_out : rd_data_out[31:0], w ? d : d[31:0]);
         end
      end
   endtask

   initial begin
      int i;
      logic [3:0] c;
      void'($urandom(20));
      repeat (10) @(posedge mclk_in);
      srst_in <= 1'b0;
      rd_valid_in <= 1'b1;
      @(posedge mclk_in);
      // Every code but the dual-address code at both widths, then random codes, addresses above and below 4 GB.
      for (i = 0; i < 140; i++) begin
         c = (i < 64) ? i[3:0] : 4'($urandom);
         if (c != 4'hd) begin
            xfer(c, {i[4] ? $urandom : 32'h0, $urandom}, (i < 64) ? i[5] : 1'($urandom));
         end
      end
      for (i = 0; i < 300 && wq.size() != 0; i++) @(posedge mclk_in);
      // Eight writes fill the stopped buffer; a ninth must wait for room.
      hold <= 1'b1;
      @(posedge mclk_in);
      repeat (8) xfer(4'h7, {32'h0, $urandom}, 1'b1);
      fork
         xfer(4'hf, {32'h1, $urandom}, 1'b0);
         begin
            repeat (30) @(posedge mclk_in);
            check("full", {wd_valid_out, req_ready_out}, 2'b10);
            hold <= 1'b0;
         end
      join
      for (i = 0; i < 300 && wq.size() != 0; i++) @(posedge mclk_in);
      check("drained", 72'(wq.size()), 72'h0);
      end_of_test();
   end

   // The tests need about a thousand cycles; this limit of 20000 leaves a wide margin.
   initial begin
      #80000;
      n_fail++;
      end_of_test();
   end
endmodule // tb_top

`default_nettype wire

// >>> bench/wide_bus_checker.sv
/*
 * Concurrent checks on the shared wide bus between the two ends.
 * Assumes it is fed the interface's signals and the bus clock.
 */
`timescale 1ns/1ps
`default_nettype none

module wide_bus_checker (
   input wire logic mclk_in, // Clock.
   input wire logic srst_in, // Synchronous reset, active high.
   input wire logic frame_n, // Frame.
   input wire logic irdy_n, // Initiator ready.
   input wire logic req64_n, // Wide request.
   input wire logic [7:0] cbe_n, // Command and enables.
   input wire logic devsel_n, // Claim.
   input wire logic trdy_n, // Target ready.
   input wire logic ack64_n, // Wide ack.
   input wire logic [63:0] ad, // Resolved lines.
   input wire logic [1:0] ad_i_oe, // Initiator drive.
   input wire logic [1:0] ad_t_oe, // Bridge drive.
   input wire logic par, // Low parity.
   input wire logic par64, // Upper parity.
   input wire logic par_i_oe, // Initiator low parity drive.
   input wire logic par_t_oe, // Bridge low parity drive.
   input wire logic par64_i_oe, // Initiator upper parity drive.
   input wire logic par64_t_oe // Bridge upper parity drive.
);
   logic [63:0] ad_q;
   logic [7:0] cbe_q;

   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (srst_in);

   // Bus lines one clock back, since parity trails them by a clock.
   always_ff @(posedge mclk_in) begin
      ad_q <= ad;
      cbe_q <= cbe_n;
   end

   property p_par64_even;
      (par64_i_oe || par64_t_oe) |-> par64 == ^{ad_q[63:32], cbe_q[7:4]};
   endproperty
   a_par64_even: assert property (p_par64_even) else $error("upper parity wrong");
   property p_par_even;
      (par_i_oe || par_t_oe) |-> par == ^{ad_q[31:0], cbe_q[3:0]};
   endproperty
   a_par_even: assert property (p_par_even) else $error("low parity wrong");
   property p_par64_init;
      ad_i_oe[1] |=> par64_i_oe;
   endproperty
   a_par64_init: assert property (p_par64_init) else $error("upper parity late");
   property p_par64_targ;
      ad_t_oe[1] |=> par64_t_oe;
   endproperty
   a_par64_targ: assert property (p_par64_targ) else $error("target upper parity");
   property p_par_init;
      ad_i_oe[0] |=> par_i_oe;
   endproperty
   a_par_init: assert property (p_par_init) else $error("low parity late");
   property p_wide_ack;
      (!irdy_n && !trdy_n && ad_i_oe[1]) |-> !ack64_n;
   endproperty
   a_wide_ack: assert property (p_wide_ack) else $error("upper data without ack");
   property p_trdy_one;
      !trdy_n |=> trdy_n;
   endproperty
   a_trdy_one: assert property (p_trdy_one) else $error("target ready too long");
   property p_reserved;
      $fell(frame_n) && cbe_n[3:0] inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9} |-> devsel_n [*6];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code claimed");
   property p_claim;
      $fell(frame_n) && !(cbe_n[3:0] inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd})
         |=> !devsel_n;
   endproperty
   a_claim: assert property (p_claim) else $error("valid code not claimed");
   property p_dac_claim;
      ($fell(frame_n) && cbe_n[3:0] == 4'hd)
         ##1 !(cbe_n[3:0] inside {4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd}) |=> !devsel_n;
   endproperty
   a_dac_claim: assert property (p_dac_claim) else $error("dual cycle not claimed");
   property p_dac_par64;
      $fell(frame_n) && cbe_n[3:0] == 4'hd && !req64_n |=> par64_i_oe ##1 par64_i_oe;
   endproperty
   a_dac_par64: assert property (p_dac_par64) else $error("dual cycle parity");
   property p_dac_upper;
      $fell(frame_n) && cbe_n[3:0] == 4'hd && !req64_n
         |=> cbe_n[3:0] == cbe_q[7:4] && ad[31:0] == ad_q[63:32];
   endproperty
   a_dac_upper: assert property (p_dac_upper) else $error("dual cycle upper half");
endmodule // wide_bus_checker

`default_nettype wire

// >>> inc/wide_bus_if.sv
/*
 * The shared 64-bit multiplexed bus joining the bridge end and the
 * initiator end. Shared lines are resolved here from each end's drive
 * and enable; an undriven line reads high as if pulled up.
 */
`timescale 1ns/1ps
`default_nettype none

interface wide_bus_if;
   logic frame_n;
   logic irdy_n;
   logic req64_n;
   logic [7:0] cbe_n;
   logic devsel_n;
   logic trdy_n;
   logic ack64_n;
   logic [63:0] ad_i;
   logic [1:0] ad_i_oe;
   logic [63:0] ad_t;
   logic [1:0] ad_t_oe;
   logic par_i;
   logic par_i_oe;
   logic par64_i;
   logic par64_i_oe;
   logic par_t;
   logic par_t_oe;
   logic par64_t;
   logic par64_t_oe;
   logic [63:0] ad;
   logic par;
   logic par64;

   assign ad[31:0] = ad_i_oe[0] ? ad_i[31:0] : (ad_t_oe[0] ? ad_t[31:0] : 32'hffffffff);
   assign ad[63:32] = ad_i_oe[1] ? ad_i[63:32] : (ad_t_oe[1] ? ad_t[63:32] : 32'hffffffff);
   assign par = par_i_oe ? par_i : (par_t_oe ? par_t : 1'b1);
   assign par64 = par64_i_oe ? par64_i : (par64_t_oe ? par64_t : 1'b1);

   modport bridge_mp (
      input frame_n, irdy_n, req64_n, cbe_n, ad, par, par64,
      output devsel_n, trdy_n, ack64_n, ad_t, ad_t_oe,
      output par_t, par_t_oe, par64_t, par64_t_oe
   );

   modport init_mp (
      input devsel_n, trdy_n, ack64_n, ad, par, par64,
      output frame_n, irdy_n, req64_n, cbe_n, ad_i, ad_i_oe,
      output par_i, par_i_oe, par64_i, par64_i_oe
   );
endinterface

`default_nettype wire

// >>> inc/wide_bus_pkg.sv
/*
 * Shared constants, types and helpers for the 64-bit wide multiplexed
 * bus between a forwarding bridge end and an initiator end.
 * Assumes both ends and the bus run on one clock and that active-low
 * pins are carried as signals whose names end in _n.
 */
`default_nettype none

package wide_bus_pkg;

   // Bus command codes, as carried on the low command/byte-enable lines.
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD = 4'h2;
   localparam logic [3:0] CMD_IO_WR = 4'h3;
   localparam logic [3:0] CMD_MEM_RD = 4'h6;
   localparam logic [3:0] CMD_MEM_WR = 4'h7;
   localparam logic [3:0] CMD_CFG_RD = 4'ha;
   localparam logic [3:0] CMD_CFG_WR = 4'hb;
   localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
   localparam logic [3:0] CMD_DUAL_ADDR = 4'hd;
   localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
   localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

   // Level driven on unused command/enable lines and on a released bus.
   localparam logic [3:0] CBE_IDLE = 4'hf;
   localparam logic [31:0] AD_PULLUP = 32'hffffffff;

   // Clocks without a target claim before an initiator gives up.
   localparam logic [2:0] DEVSEL_WAIT = 3'h5;

   // Words held by the bridge write buffer.
   localparam int WBUF_DEPTH = 8;
   localparam int WBUF_WIDTH = 72;

   // Request kinds as forwarded on the hub side.
   typedef enum logic [2:0] {
      HUB_MEM_RD = 3'h0,
      HUB_MEM_WR = 3'h1,
      HUB_IO_RD = 3'h2,
      HUB_IO_WR = 3'h3,
      HUB_CFG_RD = 3'h4,
      HUB_CFG_WR = 3'h5,
      HUB_SPECIAL = 3'h6,
      HUB_NONE = 3'h7
   } hub_kind_t;

   // Maps a bus command onto the hub request kind; reserved codes give none.
   function automatic hub_kind_t to_hub_kind(input logic [3:0] cmd);
      case (cmd)
         CMD_SPECIAL: to_hub_kind = HUB_SPECIAL;
         CMD_IO_RD: to_hub_kind = HUB_IO_RD;
         CMD_IO_WR: to_hub_kind = HUB_IO_WR;
         CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE: to_hub_kind = HUB_MEM_RD;
         CMD_MEM_WR, CMD_MEM_WR_INV: to_hub_kind = HUB_MEM_WR;
         CMD_CFG_RD: to_hub_kind = HUB_CFG_RD;
         CMD_CFG_WR: to_hub_kind = HUB_CFG_WR;
         default: to_hub_kind = HUB_NONE;
      endcase
   endfunction

   function automatic logic is_read_kind(input hub_kind_t k);
      is_read_kind = (k == HUB_MEM_RD) || (k == HUB_IO_RD) || (k == HUB_CFG_RD);
   endfunction

endpackage

`default_nettype wire

// >>> verilog/wide_bridge_end.sv
/*
 * Bridge end of the wide bus: claims cycles as a target, forwards them
 * as hub requests, buffers write data and returns read data.
 * Assumes one clock for bus and user side and a bus initiator that
 * keeps its own part of the protocol.
 */
// How it works
// R1: DAC with wide request: upper lines carry address.
// R2: Upper data moves only when both widths asserted.
// R3: First clock address on low lines, then data.
// R4: DAC wide phase: command on upper command lines.
// R5: Wide data phase: upper enables active-low.
// R6: Low command lines: command, then byte enables.
// R7: Decode special, I/O and memory commands.
// R8: Decode config, multiple, dual, line, invalidate.
// R9: Reserved commands are never claimed.
// R10: Read multiple and read line become reads.
// R11: Write and invalidate becomes plain write.
// R12: Upper parity even over upper lines and enables.
// R13: Upper parity valid after each DAC address phase with wide request.
// R14: Upper parity follows upper lines one clock late.
// R15: Low parity even over 36 bits, one clock late.
// R16: Data phase completes when both ready asserted.
// R17: Driver of upper lines also drives upper parity.
`timescale 1ns/1ps
`default_nettype none

module wide_wbuf #(
   parameter int WIDTH = wide_bus_pkg::WBUF_WIDTH,
   parameter int DEPTH = wide_bus_pkg::WBUF_DEPTH
) (
   input wire logic mclk_in, // Clock.
   input wire logic srst_in, // Synchronous reset, active high.
   input wire logic in_valid_in, // Word offered.
   input wire logic [WIDTH-1:0] in_data_in, // Word to store.
   output logic in_ready_out, // Room for a word.
   output logic out_valid_out, // Word available.
   output logic [WIDTH-1:0] out_data_out, // Oldest word.
   input wire logic out_ready_in // Drain takes the word.
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } fifo_st_t;

   fifo_st_t r;
   fifo_st_t n;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready_out = (r.cnt != CW'(DEPTH));
   assign out_valid_out = (r.cnt != '0);
   assign out_data_out = mem[r.rp];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   always_comb begin
      n = r;
      if (push) begin
         n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
      end
      n.cnt = r.cnt + CW'(push) - CW'(pop);
      if (srst_in) begin
         n = '0;
      end
   end

   always_ff @(posedge mclk_in) begin
      r <= n;
      if (push) begin
         mem[r.wp] <= in_data_in;
      end
   end
endmodule // wide_wbuf

module wide_bridge_end (
   input wire logic mclk_in, // Clock, 250 MHz.
   input wire logic srst_in, // Synchronous reset, active high.
   wide_bus_if.bridge_mp bus, // Wide bus, target side.
   output logic up_valid_out, // One-cycle pulse: a cycle was claimed.
   output wide_bus_pkg::hub_kind_t up_kind_out, // Forwarded request kind.
   output logic [63:0] up_addr_out, // Forwarded byte address.
   output logic wd_valid_out, // Buffered write word available.
   output logic [63:0] wd_data_out, // Buffered write data.
   output logic [7:0] wd_be_out, // Buffered write enables, active high.
   input wire logic wd_ready_in, // Hub side takes the write word.
   input wire logic rd_valid_in, // Read data offered by the hub side.
   input wire logic [63:0] rd_data_in, // Read data.
   output logic rd_taken_out // One-cycle pulse: read data was moved.
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR2 = 2'b01,
      ST_DATA = 2'b10,
      ST_IGNORE = 2'b11
   } bst_t;

   typedef struct packed {
      bst_t st;
      logic [3:0] cmd;
      logic [63:0] addr;
      logic wide;
      wide_bus_pkg::hub_kind_t kind;
      logic devsel_n;
      logic trdy_n;
      logic ack64_n;
      logic [63:0] ad;
      logic [1:0] ad_oe;
      logic par;
      logic par_oe;
      logic par64;
      logic par64_oe;
      logic up_valid;
      logic rd_taken;
   } bridge_st_t;

   bridge_st_t r;
   bridge_st_t n;
   logic push;
   logic fifo_ready;
   logic [71:0] push_word;
   logic [71:0] pop_word;
   wide_bus_pkg::hub_kind_t kind_now;

   always_comb begin
      n = r;
      n.up_valid = 1'b0;
      n.rd_taken = 1'b0;
      push = 1'b0;
      push_word = '0;
      kind_now = wide_bus_pkg::to_hub_kind(bus.cbe_n[3:0]);
      // R15 low parity late
      n.par = ^{r.ad[31:0], bus.cbe_n[3:0]};
      n.par_oe = r.ad_oe[0];
      // R17 own upper parity
      n.par64 = ^{r.ad[63:32], bus.cbe_n[7:4]};
      n.par64_oe = r.ad_oe[1];
      case (r.st)
         ST_IDLE: begin
            if (!bus.frame_n) begin
               // R3 address first clock
               n.addr = {32'h0, bus.ad[31:0]};
               n.cmd = bus.cbe_n[3:0];
               n.wide = !bus.req64_n;
               n.kind = kind_now;
               if (bus.cbe_n[3:0] == wide_bus_pkg::CMD_DUAL_ADDR) begin
                  // R1 upper address taken
                  if (!bus.req64_n) begin
                     n.addr[63:32] = bus.ad[63:32];
                  end
                  n.st = ST_ADDR2;
               end else if (kind_now != wide_bus_pkg::HUB_NONE) begin
                  n.st = ST_DATA;
                  n.devsel_n = 1'b0;
                  n.ack64_n = bus.req64_n;
                  n.up_valid = 1'b1;
               end else begin
                  // R9 reserved not claimed
                  n.st = ST_IGNORE;
               end
            end
         end
         ST_ADDR2: begin
            // R6 command on low lines
            n.cmd = bus.cbe_n[3:0];
            n.kind = kind_now;
            if (!r.wide) begin
               n.addr[63:32] = bus.ad[31:0];
            end
            // R7 command decode
            // R8 command decode
            if (kind_now != wide_bus_pkg::HUB_NONE) begin
               n.st = ST_DATA;
               n.devsel_n = 1'b0;
               n.ack64_n = !r.wide;
               n.up_valid = 1'b1;
            end else begin
               n.st = ST_IGNORE;
            end
         end
         ST_DATA: begin
            if (wide_bus_pkg::is_read_kind(r.kind)) begin
               // R2 upper half only if wide
               n.ad_oe = {!r.ack64_n, 1'b1};
            end
            if (!r.trdy_n) begin
               // R16 both ready completes
               if (!bus.irdy_n) begin
                  n.trdy_n = 1'b1;
                  if (wide_bus_pkg::is_read_kind(r.kind)) begin
                     n.rd_taken = 1'b1;
                  end else begin
                     push = 1'b1;
                     // R5 upper enables inverted
                     push_word[71:64] = r.ack64_n ? {4'h0, ~bus.cbe_n[3:0]} : ~bus.cbe_n;
                     push_word[63:0] = r.ack64_n ? {32'h0, bus.ad[31:0]} : bus.ad;
                  end
                  if (bus.frame_n) begin
                     n.st = ST_IDLE;
                     n.devsel_n = 1'b1;
                     n.ack64_n = 1'b1;
                     n.ad_oe = 2'b00;
                  end
               end
            end else if (wide_bus_pkg::is_read_kind(r.kind)) begin
               if (rd_valid_in && r.ad_oe[0] && !r.rd_taken) begin
                  n.trdy_n = 1'b0;
                  n.ad = rd_data_in;
               end
            end else begin
               n.trdy_n = !fifo_ready;
            end
         end
         ST_IGNORE: begin
            if (bus.frame_n && bus.irdy_n) begin
               n.st = ST_IDLE;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      if (srst_in) begin
         n = '0;
         n.st = ST_IDLE;
         n.kind = wide_bus_pkg::HUB_NONE;
         n.devsel_n = 1'b1;
         n.trdy_n = 1'b1;
         n.ack64_n = 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      r <= n;
   end

   wide_wbuf #(
      .WIDTH(wide_bus_pkg::WBUF_WIDTH),
      .DEPTH(wide_bus_pkg::WBUF_DEPTH)
   ) u_wbuf (
      .mclk_in(mclk_in),
      .srst_in(srst_in),
      .in_valid_in(push),
      .in_data_in(push_word),
      .in_ready_out(fifo_ready),
      .out_valid_out(wd_valid_out),
      .out_data_out(pop_word),
      .out_ready_in(wd_ready_in)
   );

   assign wd_data_out = pop_word[63:0];
   assign wd_be_out = pop_word[71:64];
   assign up_valid_out = r.up_valid;
   // R10 reads forwarded plain
   // R11 invalidate forwarded plain
   assign up_kind_out = r.kind;
   assign up_addr_out = r.addr;
   assign rd_taken_out = r.rd_taken;
   assign bus.devsel_n = r.devsel_n;
   assign bus.trdy_n = r.trdy_n;
   assign bus.ack64_n = r.ack64_n;
   assign bus.ad_t = r.ad;
   assign bus.ad_t_oe = r.ad_oe;
   // R12 even upper parity
   // R14 one clock behind
   assign bus.par_t = r.par;
   assign bus.par_t_oe = r.par_oe;
   assign bus.par64_t = r.par64;
   assign bus.par64_t_oe = r.par64_oe;
endmodule // wide_bridge_end

`default_nettype wire

// >>> verilog/wide_init_end.sv
/*
 * Initiator end of the wide bus: runs one single-data-phase transfer
 * per user request, with a dual address cycle for addresses above
 * four gigabytes. Assumes the same clock as the bus and its target.
 */
`timescale 1ns/1ps
`default_nettype none

module wide_init_end (
   input wire logic mclk_in, // Clock, 250 MHz.
   input wire logic srst_in, // Synchronous reset, active high.
   wide_bus_if.init_mp bus, // Wide bus, initiator side.
   input wire logic req_valid_in, // Request offered.
   input wire logic [3:0] req_cmd_in, // Bus command.
   input wire logic [63:0] req_addr_in, // Byte address.
   input wire logic req_wide_in, // Ask for a 64-bit transfer.
   input wire logic [63:0] req_data_in, // Write data.
   input wire logic [7:0] req_be_in, // Byte enables, active high.
   output logic req_ready_out, // Ready to take a request.
   output logic done_out, // One-cycle pulse: transfer finished.
   output logic abort_out, // With done: no target claimed it.
   output logic acked64_out, // With done: upper half moved.
   output logic [63:0] rd_data_out // Read data, valid with done.
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ADDR2 = 2'b01,
      ST_ADDR = 2'b10,
      ST_DATA = 2'b11
   } ist_t;

   typedef struct packed {
      ist_t st;
      logic ready;
      logic [3:0] cmd;
      logic [63:0] addr;
      logic wide;
      logic rd;
      logic [63:0] data;
      logic [7:0] be;
      logic frame_n;
      logic irdy_n;
      logic req64_n;
      logic [7:0] cbe_n;
      logic [63:0] ad;
      logic [1:0] ad_oe;
      logic par;
      logic par_oe;
      logic par64;
      logic par64_oe;
      logic [2:0] wait_cnt;
      logic done;
      logic abort;
      logic acked64;
      logic [63:0] rd_data;
   } init_st_t;

   init_st_t r;
   init_st_t n;
   logic dac;

   always_comb begin
      n = r;
      n.done = 1'b0;
      dac = (req_addr_in[63:32] != 32'h0);
      // R15 low parity late
      n.par = ^{r.ad[31:0], r.cbe_n[3:0]};
      n.par_oe = r.ad_oe[0];
      // R13 upper parity after phases
      // R17 own upper parity
      n.par64 = ^{r.ad[63:32], r.cbe_n[7:4]};
      n.par64_oe = r.ad_oe[1];
      case (r.st)
         ST_IDLE: begin
            if (req_valid_in && r.ready) begin
               n.ready = 1'b0;
               n.cmd = req_cmd_in;
               n.addr = req_addr_in;
               n.wide = req_wide_in;
               n.rd = wide_bus_pkg::is_read_kind(wide_bus_pkg::to_hub_kind(req_cmd_in));
               n.data = req_data_in;
               n.be = req_be_in;
               n.frame_n = 1'b0;
               n.req64_n = !req_wide_in;
               // R3 address on low lines
               n.ad[31:0] = req_addr_in[31:0];
               // R1 upper address lines
               n.ad[63:32] = dac ? req_addr_in[63:32] : wide_bus_pkg::AD_PULLUP;
               n.ad_oe = {req_wide_in, 1'b1};
               // R4 type on upper lines
               n.cbe_n[7:4] = dac ? req_cmd_in : wide_bus_pkg::CBE_IDLE;
               // R6 command on low lines
               n.cbe_n[3:0] = dac ? wide_bus_pkg::CMD_DUAL_ADDR : req_cmd_in;
               n.st = dac ? ST_ADDR2 : ST_ADDR;
            end
         end
         ST_ADDR2: begin
            n.ad[31:0] = r.addr[63:32];
            n.cbe_n[3:0] = r.cmd;
            n.st = ST_ADDR;
         end
         ST_ADDR: begin
            n.frame_n = 1'b1;
            n.req64_n = 1'b1;
            n.irdy_n = 1'b0;
            // R5 upper enables when wide
            n.cbe_n = {r.wide ? ~r.be[7:4] : wide_bus_pkg::CBE_IDLE, ~r.be[3:0]};
            n.ad = r.data;
            n.ad_oe = r.rd ? 2'b00 : {r.wide, 1'b1};
            n.wait_cnt = '0;
            n.st = ST_DATA;
         end
         ST_DATA: begin
            if (bus.devsel_n) begin
               n.wait_cnt = r.wait_cnt + 3'h1;
            end
            // R16 both ready completes
            if (!bus.trdy_n && !r.irdy_n) begin
               n.rd_data = bus.ad;
               // R2 upper half if acked
               n.acked64 = !bus.ack64_n && r.wide;
               n.abort = 1'b0;
               n.done = 1'b1;
            end else if (bus.devsel_n && (r.wait_cnt == wide_bus_pkg::DEVSEL_WAIT - 3'h1)) begin
               n.abort = 1'b1;
               n.acked64 = 1'b0;
               n.done = 1'b1;
            end
            if (n.done) begin
               n.irdy_n = 1'b1;
               n.ad_oe = 2'b00;
               n.cbe_n = {wide_bus_pkg::CBE_IDLE, wide_bus_pkg::CBE_IDLE};
               n.ready = 1'b1;
               n.st = ST_IDLE;
            end
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase
      if (srst_in) begin
         n = '0;
         n.st = ST_IDLE;
         n.ready = 1'b1;
         n.frame_n = 1'b1;
         n.irdy_n = 1'b1;
         n.req64_n = 1'b1;
         n.cbe_n = {wide_bus_pkg::CBE_IDLE, wide_bus_pkg::CBE_IDLE};
      end
   end

   always_ff @(posedge mclk_in) begin
      r <= n;
   end

   assign req_ready_out = r.ready;
   assign done_out = r.done;
   assign abort_out = r.abort;
   assign acked64_out = r.acked64;
   assign rd_data_out = r.rd_data;
   assign bus.frame_n = r.frame_n;
   assign bus.irdy_n = r.irdy_n;
   assign bus.req64_n = r.req64_n;
   assign bus.cbe_n = r.cbe_n;
   assign bus.ad_i = r.ad;
   assign bus.ad_i_oe = r.ad_oe;
   // R12 even upper parity
   // R14 one clock behind
   assign bus.par_i = r.par;
   assign bus.par_i_oe = r.par_oe;
   assign bus.par64_i = r.par64;
   assign bus.par64_i_oe = r.par64_oe;
endmodule // wide_init_end

`default_nettype wire
